// [hdl/aoms_buf.sv]
// Small valid/ready FIFO between the converter core and the output ports.
// Assumes a single clock; the drain side may stall, which fills it.
module aoms_buf #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	// Drain side
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	// Fill level
	output logic      [$clog2(DEPTH+1)-1:0] level_out
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_reg;
	logic [PW-1:0]    rd_reg;
	logic [CW-1:0]    cnt_reg;
	logic             push;
	logic             pop;

	initial
	begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("aoms_buf: DEPTH must be a power of two, at least 2");
	end

	assign in_ready_out  = (cnt_reg != CW'(DEPTH));
	assign out_valid_out = (cnt_reg != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem_reg[rd_reg];
	assign level_out     = cnt_reg;

	always_ff @(posedge core_clk_in)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data_in;
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg  <= push ? PW'(wr_reg + 1'b1) : wr_reg;
			rd_reg  <= pop ? PW'(rd_reg + 1'b1) : rd_reg;
			cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(pop));
		end
	end
endmodule // aoms_buf

// [hdl/aoms_pkg.sv]
// Constants, field layouts and types for the converter output mode block.
// Assumes a 40 MHz core clock and a 32-bit AHB-Lite register bus.
package aoms_pkg;
	// ==========================================================
	// Widths and register map
	// ==========================================================
	localparam int unsigned RES_W           = 16;
	localparam int unsigned BUF_DEPTH       = 2;
	localparam logic [7:0]  CFG_OFFSET      = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
	localparam logic [7:0]  RESULT_OFFSET   = 8'h08;
	// Configuration field positions.
	localparam int unsigned CFG_SWAP_BIT    = 0;
	localparam int unsigned CFG_CODING_BIT  = 1;
	localparam int unsigned CFG_FAST_BIT    = 2;
	localparam int unsigned CFG_LOWPWR_BIT  = 3;
	localparam int unsigned CFG_SERIAL_BIT  = 4;
	localparam int unsigned CFG_EXTCLK_BIT  = 5;
	localparam int unsigned CFG_RDC_BIT     = 6;
	localparam int unsigned CFG_W           = 7;
	localparam logic [6:0]  CFG_RESET       = 7'h02;
	// Data line positions of the divider inputs.
	localparam int unsigned DIV_LO_LINE     = 2;
	localparam int unsigned DIV_HI_LINE     = 3;
	localparam int unsigned PAR_ONLY_MASK_W = 2;
	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_PERIOD_NS   = 25;
	localparam int unsigned SCLK_BASE_NS    = 8;
	// Half period of the internal serial clock in core cycles, least time rounded up.
	function automatic logic [3:0] sclk_half_cyc(input logic [1:0] code);
		int unsigned ns;
		int unsigned c;
		ns = SCLK_BASE_NS << code;
		c = (ns + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
		if (c < 1)
			c = 1;
		return c[3:0];
	endfunction
	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {AOMS_NORMAL, AOMS_FAST, AOMS_WIDE, AOMS_LOWPWR} aoms_mode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} aoms_state_t;
endpackage

// [hdl/aoms_sync.sv]
// Two-stage synchroniser for pins arriving from outside the core clock.
// Assumes the pins are static or slow against the core clock.
module aoms_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	// Pins and synchronised copy
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	initial
	begin
		if (WIDTH < 1)
			$error("aoms_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule // aoms_sync

// [hdl/aoms_top.sv]
// Output mode control of a 16-bit sampling converter: mode decode, result
// coding, byte order, parallel port and master/slave serial port.
// Assumes results arrive from the converter core on the core clock, and
// chip select, external serial clock and data line inputs come from pins.
module aoms_top (
	// Clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       rst_in,
	// AHB-Lite slave
	input  wire logic                       hsel_in,
	input  wire logic [31:0]                haddr_in,
	input  wire logic [1:0]                 htrans_in,
	input  wire logic                       hwrite_in,
	input  wire logic [2:0]                 hsize_in,
	input  wire logic [31:0]                hwdata_in,
	input  wire logic                       hready_in,
	output logic      [31:0]                hrdata_out,
	output logic                            hreadyout_out,
	output logic                            hresp_out,
	// Converter core side
	input  wire logic [aoms_pkg::RES_W-1:0] result_in,
	input  wire logic                       result_valid_in,
	output logic                            result_ready_out,
	input  wire logic                       conv_busy_in,
	output aoms_pkg::aoms_mode_t            conv_mode_out,
	// Data lines
	input  wire logic [aoms_pkg::RES_W-1:0] data_in,
	output logic      [aoms_pkg::RES_W-1:0] data_out,
	output logic      [aoms_pkg::RES_W-1:0] data_oe_out,
	// Serial port
	input  wire logic                       cs_n_in,
	input  wire logic                       sclk_in,
	output logic                            sclk_out,
	output logic                            sclk_oe_out,
	output logic                            sdout_out,
	output logic                            sdout_oe_out,
	output logic                            sync_out,
	output logic                            sync_oe_out
);
	import aoms_pkg::*;

	// ==========================================================
	// Declarations
	// ==========================================================
	logic [CFG_W-1:0] cfg_reg;
	logic [CFG_W-1:0] act_cfg_reg;
	logic             wr_pend_reg;
	logic [7:0]       wr_addr_reg;
	logic [31:0]      hrdata_reg;
	logic [RES_W-1:0] last_word_reg;
	logic [RES_W-1:0] par_word_reg;
	logic [RES_W-1:0] shift_reg;
	logic [4:0]       bit_cnt_reg;
	logic [3:0]       div_cnt_reg;
	logic             sclk_reg;
	logic             sync_reg;
	logic             ext_sclk_d_reg;
	aoms_state_t      state_reg;
	aoms_state_t      state_next;
	logic [RES_W-1:0] buf_data;
	logic             buf_valid;
	logic             buf_ready;
	logic [1:0]       buf_level;
	logic [3:0]       pins_s;
	logic             cs_n_s;
	logic             ext_sclk_s;
	logic [1:0]       div_s;
	logic             addr_phase;
	logic             pop;
	logic             is_serial;
	logic             is_master;
	logic             read_during_conversion_select;
	logic             ext_rise;
	logic             half_done;
	logic [RES_W-1:0] coded_word;
	logic [3:0]       half_cyc;
	logic [31:0]      status_word;

	// ==========================================================
	// Pin synchronisers and buffer
	// ==========================================================
	// Chip select enters inverted, so the cleared synchroniser reads as deselected.
	aoms_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.core_clk_in(core_clk_in),
		.rst_in     (rst_in),
		.pin_in     ({data_in[DIV_HI_LINE], data_in[DIV_LO_LINE], sclk_in, ~cs_n_in}),
		.sync_out   (pins_s)
	);

	assign cs_n_s     = ~pins_s[0];
	assign ext_sclk_s = pins_s[1];
	assign div_s      = pins_s[3:2];

	// A stall of the serial port holds words here so none are dropped.
	aoms_buf #(
		.WIDTH(RES_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.core_clk_in  (core_clk_in),
		.rst_in       (rst_in),
		.in_data_in   (result_in),
		.in_valid_in  (result_valid_in),
		.in_ready_out (result_ready_out),
		.out_data_out (buf_data),
		.out_valid_out(buf_valid),
		.out_ready_in (buf_ready),
		.level_out    (buf_level)
	);

	// ==========================================================
	// Register bus
	// ==========================================================
	assign addr_phase    = hsel_in && hready_in && htrans_in[1];
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign hrdata_out    = hrdata_reg;

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end
		else
		begin
			wr_pend_reg <= addr_phase && hwrite_in && (hsize_in == 3'h2) && (haddr_in[31:8] == 24'h00_0000);
			wr_addr_reg <= haddr_in[7:0];
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			cfg_reg <= CFG_RESET;
		else if (wr_pend_reg && wr_addr_reg == CFG_OFFSET)
			cfg_reg <= hwdata_in[CFG_W-1:0];
	end

	assign status_word = {16'h0000, 4'h0, div_s, buf_level, 2'h0, conv_mode_out,
		cs_n_s, buf_valid, (state_reg != ST_IDLE), is_serial};

	// Read data are taken in the address phase so they stand in the data phase.
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			hrdata_reg <= '0;
		else if (addr_phase && !hwrite_in)
		begin
			case (haddr_in[7:0])
				CFG_OFFSET:    hrdata_reg <= {25'h000_0000, cfg_reg};
				STATUS_OFFSET: hrdata_reg <= status_word;
				RESULT_OFFSET: hrdata_reg <= {16'h0000, last_word_reg};
				default:       hrdata_reg <= '0;
			endcase
		end
	end

	// ==========================================================
	// Mode decode and active configuration
	// ==========================================================
	// The written configuration reaches the port logic only while no word is
	// moving, so a result is never split between two formats.
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			act_cfg_reg <= CFG_RESET;
		else if (state_reg == ST_IDLE && !pop)
			act_cfg_reg <= cfg_reg;
	end

	assign is_serial = act_cfg_reg[CFG_SERIAL_BIT];
	assign is_master = !act_cfg_reg[CFG_EXTCLK_BIT];
	assign read_during_conversion_select       = act_cfg_reg[CFG_RDC_BIT];

	always_comb
	begin
		case ({act_cfg_reg[CFG_FAST_BIT], act_cfg_reg[CFG_LOWPWR_BIT]})
			2'b11:   conv_mode_out = AOMS_WIDE;
			2'b10:   conv_mode_out = AOMS_FAST;
			2'b01:   conv_mode_out = AOMS_LOWPWR;
			default: conv_mode_out = AOMS_NORMAL;
		endcase
	end

	// Straight binary passes through; otherwise the top bit flips.
	always_comb
	begin
		coded_word = buf_data;
		if (!act_cfg_reg[CFG_CODING_BIT])
			coded_word[RES_W-1] = ~buf_data[RES_W-1];
	end

	// ==========================================================
	// Word hand-off
	// ==========================================================
	// In master read-after-conversion the word waits for the conversion to end;
	// reading during conversion sends the previous result at once.
	always_comb
	begin
		if (!is_serial)
			buf_ready = 1'b1;
		else if (state_reg != ST_IDLE || cs_n_s)
			buf_ready = 1'b0;
		else if (is_master)
			buf_ready = read_during_conversion_select || !conv_busy_in;
		else
			buf_ready = 1'b1;
	end

	assign pop = buf_valid && buf_ready;

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			last_word_reg <= '0;
		else if (pop)
			last_word_reg <= coded_word;
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			par_word_reg <= '0;
		else if (pop && !is_serial)
		begin
			if (act_cfg_reg[CFG_SWAP_BIT])
				par_word_reg <= {coded_word[7:0], coded_word[15:8]};
			else
				par_word_reg <= coded_word;
		end
	end

	// ==========================================================
	// Serial shift engine
	// ==========================================================
	// Reading during conversion runs at the base period; the divider pins
	// only act in master read-after-conversion.
	assign half_cyc  = sclk_half_cyc(read_during_conversion_select ? 2'b00 : div_s);
	assign half_done = (div_cnt_reg == 4'h1);
	assign ext_rise  = ext_sclk_s && !ext_sclk_d_reg;

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			ext_sclk_d_reg <= 1'b0;
		else
			ext_sclk_d_reg <= ext_sclk_s;
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (pop && is_serial)
					state_next = is_master ? ST_MASTER : ST_SLAVE;
			end
			ST_MASTER:
			begin
				if (cs_n_s)
					state_next = ST_IDLE;
				else if (half_done && sclk_reg && bit_cnt_reg == 5'h0f)
					state_next = ST_IDLE;
			end
			ST_SLAVE:
			begin
				if (cs_n_s)
					state_next = ST_IDLE;
				else if (ext_rise && bit_cnt_reg == 5'h0f)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Master: the clock toggles every half period and data move on its fall.
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_cnt_reg <= '0;
			sclk_reg    <= 1'b0;
			sync_reg    <= 1'b0;
		end
		else if (state_reg == ST_IDLE)
		begin
			div_cnt_reg <= half_cyc;
			sclk_reg    <= 1'b0;
			sync_reg    <= pop && is_serial && is_master;
		end
		else if (state_reg == ST_MASTER)
		begin
			div_cnt_reg <= half_done ? half_cyc : 4'(div_cnt_reg - 1'b1);
			if (half_done)
				sclk_reg <= ~sclk_reg;
			if (state_next == ST_IDLE)
				sync_reg <= 1'b0;
		end
		else
			sync_reg <= 1'b0;
	end

	// Both ends shift most significant bit first.
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			shift_reg   <= '0;
			bit_cnt_reg <= '0;
		end
		else if (state_reg == ST_IDLE)
		begin
			bit_cnt_reg <= '0;
			if (pop && is_serial)
				shift_reg <= coded_word;
		end
		else if ((state_reg == ST_MASTER && half_done && sclk_reg) ||
			(state_reg == ST_SLAVE && ext_rise))
		begin
			shift_reg   <= {shift_reg[RES_W-2:0], 1'b0};
			bit_cnt_reg <= 5'(bit_cnt_reg + 1'b1);
		end
	end

	// ==========================================================
	// Pin drive
	// ==========================================================
	always_comb
	begin
		data_out    = par_word_reg;
		data_oe_out = '0;
		if (!is_serial)
			data_oe_out = '1;
		else
		begin
			// Serial data leave on their own pins; every data line floats,
			// the divider lines included, since they are inputs or unused.
			data_out    = '0;
			data_oe_out = '0;
		end
	end

	assign sclk_out     = sclk_reg;
	assign sclk_oe_out  = is_serial && is_master && !cs_n_s;
	assign sdout_out    = shift_reg[RES_W-1];
	assign sdout_oe_out = is_serial && !cs_n_s;
	assign sync_out     = sync_reg;
	assign sync_oe_out  = is_serial && is_master && !cs_n_s;
endmodule // aoms_top

// [tb/aoms_checker.sv]
// Concurrent checks on the pins of the converter output mode block.
// Assumes one core clock; the bind at the foot attaches it to every instance.
module aoms_checker (
	input wire logic        core_clk_in,
	input wire logic        rst_in,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe_out,
	input wire logic        sclk_out,
	input wire logic        sclk_oe_out,
	input wire logic        sdout_oe_out,
	input wire logic        sync_out,
	input wire logic        sync_oe_out
);
	logic       sclk_q;
	logic [4:0] edge_cnt;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// Serial clock edge counter
	// ==========================================================
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sclk_q   <= 1'b0;
			edge_cnt <= 5'h00;
		end
		else
		begin
			sclk_q <= sclk_out;
			if (!sync_out)
				edge_cnt <= 5'h00;
			else if (sclk_out && !sclk_q)
				edge_cnt <= edge_cnt + 5'h01;
		end
	end
	sequence s_rise;
		sync_out && sclk_out && !sclk_q;
	endsequence
	sequence s_fall;
		##[1:2] !sclk_out;
	endsequence
	// ==========================================================
	// Properties
	// ==========================================================
	chk_oe_uniform: assert property (data_oe_out == 16'hffff || data_oe_out == 16'h0000)
		else $error("data line enables are mixed");
	chk_serial_quiet: assert property (data_oe_out == 16'h0000 |-> data_out == 16'h0000)
		else $error("data lines carry a value while released");
	chk_master_pins: assert property (sclk_oe_out |-> sdout_oe_out && data_oe_out == 16'h0000)
		else $error("serial clock driven outside serial mode");
	chk_sdout_serial: assert property (sdout_oe_out |-> data_oe_out == 16'h0000)
		else $error("serial data driven beside parallel lines");
	chk_oe_pair: assert property (sync_oe_out == sclk_oe_out)
		else $error("frame sync and serial clock enables differ");
	chk_sclk_framed: assert property (sclk_out && sclk_oe_out |-> sync_out)
		else $error("serial clock high outside a frame");
	chk_sclk_rate: assert property (s_rise |-> s_fall)
		else $error("serial clock high phase too long");
	chk_frame_len: assert property ($fell(sync_out) && sync_oe_out |-> edge_cnt == 5'h10)
		else $error("frame ended without sixteen clock edges");
	chk_sync_start: assert property ($rose(sync_out) |-> !sclk_out)
		else $error("frame began with the serial clock high");
endmodule // aoms_checker

bind aoms_top aoms_checker u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .data_out(data_out),
	.data_oe_out(data_oe_out), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out),
	.sdout_oe_out(sdout_oe_out), .sync_out(sync_out), .sync_oe_out(sync_oe_out));

// [tb/aoms_host_model.sv]
// Host model: chip select, external serial clock and capture of result words.
// Assumes the core clock; frames are started by the bench one at a time.
module aoms_host_model (
	input  wire logic        clk_in,
	input  wire logic        sclk_in,
	input  wire logic        sync_in,
	input  wire logic        sdout_in,
	output logic             cs_n_out,
	output logic             sclk_out,
	output logic             done_out,
	output logic [15:0]      word_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] n;
	logic       sq;
	logic       ck;
	assign ck = sync_in ? sclk_in : sclk_out;
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		done_out = 1'b0;
		word_out = 16'h0000;
		n = 5'h00;
		sq = 1'b0;
	end
	// Data is sampled on the rising clock; the device moves it on the falling one as master, after the synchronised rising one as slave.
	always @(posedge clk_in)
	begin
		sq <= ck;
		done_out <= (n == 5'h10);
		if (cs_n_out || n == 5'h10)
			n <= 5'h00;
		else if (ck && !sq)
		begin
			word_out <= {word_out[14:0], sdout_in};
			n <= n + 5'h01;
		end
	end
	task set_cs(input logic v);
		cs_n_out <= v;
	endtask
	// The external clock is slow because the device synchronises it.
	task slave_frame();
		cs_n_out <= 1'b0;
		repeat (8) @(posedge clk_in);
		repeat (16)
		begin
			sclk_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			sclk_out <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
		cs_n_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
endmodule // aoms_host_model

// [tb/aoms_top_tb_top.sv]
// Self-checking bench for the converter output mode block.
// Assumes the package constants; the host model sits on the serial pins.
module aoms_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import aoms_pkg::*;
	logic        clk, rst, hsel, hwrite, valid, busy, cs_n, hsclk, done, hrdy, hresp, rdy;
	logic        sclk, sclk_oe, sdout, sdout_oe, sync, sync_oe;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  cfg;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [15:0] res, dout, doe, drv, din, word, last, mon_last;
	aoms_mode_t  mode;
	logic [15:0] exp_q[$];
	int          n_fail, tests_run, i;
	assign din = (dout & doe) | (drv & ~doe);
	aoms_top uut (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(hresp), .result_in(res), .result_valid_in(valid),
		.result_ready_out(rdy), .conv_busy_in(busy), .conv_mode_out(mode), .data_in(din), .data_out(dout),
		.data_oe_out(doe), .cs_n_in(cs_n), .sclk_in(hsclk), .sclk_out(sclk), .sclk_oe_out(sclk_oe),
		.sdout_out(sdout), .sdout_oe_out(sdout_oe), .sync_out(sync), .sync_oe_out(sync_oe));
	aoms_host_model host (.clk_in(clk), .sclk_in(sclk), .sync_in(sync), .sdout_in(sdout), .cs_n_out(cs_n),
		.sclk_out(hsclk), .done_out(done), .word_out(word));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ==========================================================
	// Shared tasks
	// ==========================================================
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [15:0] coded(input logic [15:0] r, input logic [6:0] c, input logic par);
		logic [15:0] v;
		v = {r[15] ^ ~c[CFG_CODING_BIT], r[14:0]};
		return (par && c[CFG_SWAP_BIT]) ? {v[7:0], v[15:8]} : v;
	endfunction
	task report_and_stop;
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task take(input string nm, input logic [15:0] seen);
		if (exp_q.size() == 0)
		begin
			n_fail++;
			$display("Error %s expected none seen %h", nm, seen);
		end
		else
			check(nm, {16'h0000, seen}, {16'h0000, exp_q.pop_front()});
	endtask
	task wait_for(input int kind);
		int k;
		for (k = 0; k < 3000; k++)
		begin
			@(posedge clk);
			if ((kind == 0 && hrdy === 1'b1) || (kind == 1 && rdy === 1'b1) || (kind == 2 && exp_q.size() == 0))
				return;
		end
		n_fail++;
		report_and_stop;
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		hsize <= 3'b010;
		wait_for(0);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_for(0);
		rd = hrdata;
	endtask
	task wcfg(input logic [6:0] c);
		cfg = c;
		ahb(1'b1, {24'h0000_00, CFG_OFFSET}, {25'h0000_000, c});
		repeat (3) @(posedge clk);
	endtask
	// Words offered to the parallel port always differ, so the monitor sees each one arrive.
	task push(input logic par);
		logic [15:0] r;
		seed = lfsr(seed);
		r = seed[15:0];
		if (par && coded(r, cfg, par) === last)
			r[0] = ~r[0];
		if (par)
			last = coded(r, cfg, par);
		exp_q.push_back(coded(r, cfg, par));
		res <= r;
		valid <= 1'b1;
		wait_for(1);
		valid <= 1'b0;
		@(posedge clk);
	endtask
	// ==========================================================
	// Output monitor
	// ==========================================================
	always @(posedge clk)
	begin
		if (!rst && done === 1'b1)
			take("serial word", word);
		if (!rst && doe === 16'hffff && dout !== mon_last)
			take("parallel word", dout);
		mon_last = dout;
	end
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		{rst, hsel, hwrite, valid, busy} = 5'h10;
		{htrans, hsize, haddr, hwdata, res, drv} = '0;
		seed = 32'h75c8_87f7;
		{n_fail, tests_run, last, mon_last} = '0;
		cfg = CFG_RESET;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, {24'h0000_00, CFG_OFFSET}, 32'h0000_0000);
		check("cfg reset", rd, {25'h0000_000, CFG_RESET});
		check("okay response", hresp, 1'b0);
		ahb(1'b1, 32'h0000_000c, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_000c, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		ahb(1'b1, 32'h0000_0100, 32'hffff_ffff);
		ahb(1'b0, {24'h0000_00, CFG_OFFSET}, 32'h0000_0000);
		check("high address write", rd, {25'h0000_000, CFG_RESET});
		// Fast modes stay selected only a few cycles, so no gap between starts grows long.
		for (i = 0; i < 4; i++)
		begin
			wcfg({3'b000, i[1:0], 2'b10});
			check("mode", mode, {i[1], i[0] ^ i[1]});
			ahb(1'b0, {24'h0000_00, STATUS_OFFSET}, 32'h0000_0000);
			check("status mode", rd[5:4], {i[1], i[0] ^ i[1]});
		end
		for (i = 0; i < 4; i++)
		begin
			wcfg({5'b00000, i[1:0]});
			push(1'b1);
			push(1'b1);
			repeat (4) @(posedge clk);
		end
		check("parallel enables", doe, 16'hffff);
		// The last parallel words went out byte swapped; the register keeps them unswapped.
		ahb(1'b0, {24'h0000_00, RESULT_OFFSET}, 32'h0000_0000);
		check("result register", rd, {16'h0000, last[7:0], last[15:8]});
		drv <= 16'h000c;
		wcfg(7'h10);
		check("serial enables", doe, 16'h0000);
		push(1'b0);
		push(1'b0);
		@(posedge clk);
		check("buffer full", rdy, 1'b0);
		ahb(1'b0, {24'h0000_00, STATUS_OFFSET}, 32'h0000_0000);
		check("divider pins", rd[11:10], 2'b11);
		host.set_cs(1'b0);
		wait_for(2);
		repeat (8) @(posedge clk);
		busy <= 1'b1;
		push(1'b0);
		repeat (40) @(posedge clk);
		check("held while converting", exp_q.size(), 1);
		wcfg(7'h50);
		wait_for(2);
		repeat (8) @(posedge clk);
		host.set_cs(1'b1);
		busy <= 1'b0;
		wcfg(7'h32);
		// One word a frame: a second buffered word would start as soon as the first ends.
		push(1'b0);
		host.set_cs(1'b0);
		repeat (3) @(posedge clk);
		check("slave clock enable", sclk_oe, 1'b0);
		check("slave data enable", sdout_oe, 1'b1);
		host.slave_frame();
		push(1'b0);
		host.slave_frame();
		check("slave drained", exp_q.size(), 0);
		report_and_stop;
	end
endmodule // aoms_top_tb_top
